//--- i2c_master_bus_sequencer.sv
/*
  Two-wire bus master sequencer: Start and Repeated Start generation with
  collision checks, byte transmit with acknowledge capture, byte receive,
  and a Wishbone classic register slave.
  Assumes open-drain pads outside: each line is released when its enable is
  low and pulled low when high; the pad inputs are asynchronous to clk_i.
*/
// Added by the designer: the register addresses and the Wishbone interface to the registers.
// Notes on behaviour
// - Start request with both lines high loads baud counter from reload low byte.
// - On count expiry with lines high, pull data low and flag start detected.
// - Count one more period, then clear start request and stop counter.
// - Line low at Start begin or clock low early flags collision, aborts.
// - Repeated start in idle pulls clock low, then releases data one period.
// - Data high: release clock, wait high, data low one period, clock low, done.
// - Start detected flag immediately; interrupt only after the baud timeout.
// - Repeated start request while another event runs is ignored.
// - Repeated start collides on data low at clock rise or early clock low.
// - Buffer write sets buffer full and starts transmitting the byte.
// - Each bit: data after clock falls, clock low one period, high one period.
// - After the eighth clock falls, clear buffer full and release data.
// - Ninth-bit acknowledge: low clears ack status, high sets it.
// - After ninth clock set interrupt, stop counter, clock low, data unchanged.
// - Buffer write during a transfer sets write collision, buffer unchanged.
// - Receive toggles clock each rollover and shifts data line in.
// - After eighth received clock: clear enable, copy byte, set full and irq.
// - Reading the received byte clears buffer full.
// - Released clock holds the counter until sampled high, then reloads.
// - Reset or disable returns to idle and ends any transfer.
`timescale 1ns/100ps
module i2c_master_bus_sequencer (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave.
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Clock line pad.
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_o,
  // Data line pad.
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o
);
  import i2c_seq_pkg::*;

  seq_state_e  state_q;
  logic [2:0]  scl_sync_q;
  logic [2:0]  sda_sync_q;
  logic        scl_f_q;
  logic        sda_f_q;
  logic        sda_prev_q;
  logic [7:0]  cnt_q;
  logic [7:0]  baud_q;
  logic        enable_q;
  logic        start_req_q;
  logic        rstart_req_q;
  logic        recv_q;
  logic        scl_oe_q;
  logic        sda_oe_q;
  logic [3:0]  bits_q;
  logic [7:0]  shift_q;
  logic [7:0]  data_buf_q;
  logic        rx_mode_q;
  logic        ack_stat_q;
  logic        bf_q;
  logic        sdet_q;
  logic        irq_q;
  logic        write_collision_q;
  logic        bcol_q;
  logic        ev_irq_q;
  logic        ev_bcol_q;
  logic        ev_bf_set_q;
  logic        ev_bf_clr_q;
  logic        ack_q;
  logic [31:0] dat_q;
  logic        req;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        wr_baud;
  logic        wr_data;
  logic        rd_data;
  logic        idle_ok;
  logic        tx_go;
  logic        tick;
  logic        coll;

  // Bus request is taken in the cycle before ack, and ack lasts one cycle.
  assign req     = cyc_i & stb_i & ~ack_q;
  assign wr_ctrl = req & we_i & sel_i[0] & (adr_i == OFF_CTRL);
  assign wr_stat = req & we_i & sel_i[0] & (adr_i == OFF_STAT);
  assign wr_baud = req & we_i & sel_i[0] & (adr_i == OFF_BAUD);
  assign wr_data = req & we_i & sel_i[0] & (adr_i == OFF_DATA);
  assign rd_data = req & ~we_i & (adr_i == OFF_DATA);

  // No queuing: a new command is only accepted with nothing pending.
  assign idle_ok = (state_q == S_IDLE) & ~start_req_q & ~rstart_req_q & ~recv_q;
  assign tx_go   = wr_data & idle_ok;
  assign tick    = (cnt_q == 8'h00);

  // Collision checks while a Start or Repeated Start is under way.
  assign coll = ((state_q == S_ST_WAIT) & (~scl_f_q | (tick & ~sda_f_q)))
              | ((state_q == S_RS_REL) & tick & ~sda_f_q)
              | ((state_q == S_RS_SCLW) & scl_f_q & ~sda_f_q)
              | ((state_q == S_RS_HIGH) & ~scl_f_q);

  // Pads are open-drain: output level is always low, only the enable moves.
  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe_o = scl_oe_q;
  assign sda_oe_o = sda_oe_q;
  assign ack_o    = ack_q;
  assign dat_o    = dat_q;

  // Three-stage sampling; a level is believed once stages two and three agree.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      scl_f_q    <= 1'b1;
      sda_f_q    <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], scl_i};
      sda_sync_q <= {sda_sync_q[1:0], sda_i};
      if (scl_sync_q[1] == scl_sync_q[2]) begin
        scl_f_q <= scl_sync_q[2];
      end
      if (sda_sync_q[1] == sda_sync_q[2]) begin
        sda_f_q <= sda_sync_q[2];
      end
      sda_prev_q <= sda_f_q;
    end
  end

  // Software settings that do not belong to the sequencer itself.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      baud_q   <= BAUD_RST;
      enable_q <= EN_RST;
    end else begin
      if (wr_baud) begin
        baud_q <= dat_i[7:0];
      end
      if (wr_ctrl) begin
        enable_q <= dat_i[CTL_EN];
      end
    end
  end

  // Sequencer: owns the requests, the baud counter, the line drives and the
  // shift register, so that a finished command never reappears for a cycle.
  always_ff @(posedge clk_i) begin
    ev_irq_q    <= 1'b0;
    ev_bcol_q   <= 1'b0;
    ev_bf_set_q <= 1'b0;
    ev_bf_clr_q <= 1'b0;
    if (rst_i || !enable_q) begin
      state_q      <= S_IDLE;
      start_req_q  <= 1'b0;
      rstart_req_q <= 1'b0;
      recv_q       <= 1'b0;
      scl_oe_q     <= 1'b0;
      sda_oe_q     <= 1'b0;
      cnt_q        <= 8'h00;
      bits_q       <= 4'h0;
      shift_q      <= 8'h00;
      data_buf_q   <= 8'h00;
      rx_mode_q    <= 1'b0;
      ack_stat_q   <= 1'b0;
    end else begin
      if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
      if (coll) begin
        state_q      <= S_IDLE;
        start_req_q  <= 1'b0;
        rstart_req_q <= 1'b0;
        scl_oe_q     <= 1'b0;
        sda_oe_q     <= 1'b0;
        ev_bcol_q    <= 1'b1;
      end else begin
        unique case (state_q)
          S_IDLE: begin
            // Requests written while busy were never stored, hence ignored.
            if (wr_ctrl && idle_ok) begin
              start_req_q  <= dat_i[CTL_START];
              rstart_req_q <= dat_i[CTL_RSTART];
              recv_q       <= dat_i[CTL_RECV];
            end else if (start_req_q) begin
              if (scl_f_q && sda_f_q) begin
                cnt_q   <= baud_q;
                state_q <= S_ST_WAIT;
              end else begin
                start_req_q <= 1'b0;
                ev_bcol_q   <= 1'b1;
              end
            end else if (rstart_req_q) begin
              scl_oe_q <= 1'b1;
              state_q  <= S_RS_LOW;
            end else if (recv_q) begin
              rx_mode_q <= 1'b1;
              sda_oe_q  <= 1'b0;
              scl_oe_q  <= 1'b1;
              bits_q    <= 4'h0;
              cnt_q     <= baud_q;
              state_q   <= S_BIT_LOW;
            end else if (tx_go) begin
              rx_mode_q   <= 1'b0;
              shift_q     <= dat_i[7:0];
              data_buf_q  <= dat_i[7:0];
              ev_bf_set_q <= 1'b1;
              scl_oe_q    <= 1'b1;
              bits_q      <= 4'h0;
              cnt_q       <= baud_q;
              state_q     <= S_BIT_LOW;
            end
          end
          S_ST_WAIT: begin
            if (tick) begin
              sda_oe_q <= 1'b1;
              cnt_q    <= baud_q;
              state_q  <= S_ST_HOLD;
            end
          end
          S_ST_HOLD: begin
            if (tick) begin
              start_req_q <= 1'b0;
              ev_irq_q    <= 1'b1;
              state_q     <= S_IDLE;
            end
          end
          S_RS_LOW: begin
            if (!scl_f_q) begin
              sda_oe_q <= 1'b0;
              cnt_q    <= baud_q;
              state_q  <= S_RS_REL;
            end
          end
          S_RS_REL: begin
            if (tick) begin
              scl_oe_q <= 1'b0;
              state_q  <= S_RS_SCLW;
            end
          end
          S_RS_SCLW: begin
            if (scl_f_q) begin
              cnt_q   <= baud_q;
              state_q <= S_RS_HIGH;
            end
          end
          S_RS_HIGH: begin
            if (tick) begin
              sda_oe_q <= 1'b1;
              cnt_q    <= baud_q;
              state_q  <= S_RS_SDALO;
            end
          end
          S_RS_SDALO: begin
            if (tick) begin
              scl_oe_q     <= 1'b1;
              rstart_req_q <= 1'b0;
              ev_irq_q     <= 1'b1;
              state_q      <= S_IDLE;
            end
          end
          S_BIT_LOW: begin
            // Data moves one cycle after the clock is pulled low, never at that edge.
            // Limitation: with a zero reload the data change meets the clock release.
            if (cnt_q == baud_q && !rx_mode_q) begin
              sda_oe_q <= (bits_q != BIT_ACK) & ~shift_q[7];
            end
            if (tick) begin
              scl_oe_q <= 1'b0;
              state_q  <= S_BIT_SCLW;
            end
          end
          S_BIT_SCLW: begin
            // A slave may stretch the low time; the high period starts here.
            if (scl_f_q) begin
              cnt_q   <= baud_q;
              state_q <= S_BIT_HIGH;
              if (rx_mode_q) begin
                shift_q <= {shift_q[6:0], sda_f_q};
              end else if (bits_q == BIT_ACK) begin
                ack_stat_q <= sda_f_q;
              end
            end
          end
          S_BIT_HIGH: begin
            if (tick) begin
              scl_oe_q <= 1'b1;
              bits_q   <= bits_q + 4'h1;
              if (rx_mode_q && bits_q == BIT_LAST_DATA) begin
                recv_q      <= 1'b0;
                data_buf_q  <= shift_q;
                ev_bf_set_q <= 1'b1;
                ev_irq_q    <= 1'b1;
                state_q     <= S_IDLE;
              end else if (!rx_mode_q && bits_q == BIT_LAST_DATA) begin
                ev_bf_clr_q <= 1'b1;
                cnt_q       <= baud_q;
                state_q     <= S_BIT_LOW;
              end else if (!rx_mode_q && bits_q == BIT_ACK) begin
                ev_irq_q <= 1'b1;
                state_q  <= S_IDLE;
              end else begin
                if (!rx_mode_q) begin
                  shift_q <= {shift_q[6:0], 1'b0};
                end
                cnt_q   <= baud_q;
                state_q <= S_BIT_LOW;
              end
            end
          end
        endcase
      end
    end
  end

  // Sticky status flags; write one to clear all but buffer full, and a set in the same cycle wins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bf_q   <= 1'b0;
      sdet_q <= 1'b0;
      irq_q  <= 1'b0;
      write_collision_q <= 1'b0;
      bcol_q <= 1'b0;
    end else begin
      if (ev_bf_set_q) begin
        bf_q <= 1'b1;
      end else if (ev_bf_clr_q || (rd_data && rx_mode_q)) begin
        bf_q <= 1'b0;
      end
      if (sda_prev_q && !sda_f_q && scl_f_q) begin
        sdet_q <= 1'b1;
      end else if (wr_stat && dat_i[STA_SDET]) begin
        sdet_q <= 1'b0;
      end
      if (ev_irq_q) begin
        irq_q <= 1'b1;
      end else if (wr_stat && dat_i[STA_IRQ]) begin
        irq_q <= 1'b0;
      end
      if (wr_data && !idle_ok) begin
        write_collision_q <= 1'b1;
      end else if (wr_stat && dat_i[STA_WRITE_COLLISION]) begin
        write_collision_q <= 1'b0;
      end
      if (ev_bcol_q) begin
        bcol_q <= 1'b1;
      end else if (wr_stat && dat_i[STA_BCOL]) begin
        bcol_q <= 1'b0;
      end
    end
  end

  // Registered read data and single-cycle ack; unmapped offsets read zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (req) begin
        dat_q <= 32'h0000_0000;
        unique case (adr_i)
          OFF_CTRL: begin
            dat_q[CTL_START]   <= start_req_q;
            dat_q[CTL_RSTART]  <= rstart_req_q;
            dat_q[CTL_RECV]    <= recv_q;
            dat_q[CTL_ACK_STATUS] <= ack_stat_q;
            dat_q[CTL_EN]      <= enable_q;
          end
          OFF_STAT: begin
            dat_q[STA_BF]   <= bf_q;
            dat_q[STA_SDET] <= sdet_q;
            dat_q[STA_IRQ]  <= irq_q;
            dat_q[STA_WRITE_COLLISION] <= write_collision_q;
            dat_q[STA_BCOL] <= bcol_q;
            dat_q[STA_BUSY] <= (state_q != S_IDLE);
          end
          OFF_BAUD: begin
            dat_q[7:0] <= baud_q;
          end
          OFF_DATA: begin
            dat_q[7:0] <= data_buf_q;
          end
          default: begin end
        endcase
      end
    end
  end

endmodule // i2c_master_bus_sequencer

//--- i2c_seq_pkg.sv
/*
  Shared constants for the two-wire bus master sequencer: register offsets,
  bit positions, reset values, bit counts and the sequencer state codes.
  Assumes a 32-bit classic Wishbone register port with byte addresses.
*/
package i2c_seq_pkg;

  // Register byte offsets.
  localparam logic [3:0] OFF_CTRL = 4'h0;  // bus_control_two
  localparam logic [3:0] OFF_STAT = 4'h4;  // serial_status_reg
  localparam logic [3:0] OFF_BAUD = 4'h8;  // baud_reload_reg
  localparam logic [3:0] OFF_DATA = 4'hC;  // data_buffer

  // Control register bit positions.
  localparam int CTL_START   = 0;
  localparam int CTL_RSTART  = 1;
  localparam int CTL_RECV    = 3;
  localparam int CTL_ACK_STATUS = 6;
  localparam int CTL_EN      = 7;

  // Status register bit positions.
  localparam int STA_BF   = 0;
  localparam int STA_SDET = 1;
  localparam int STA_IRQ  = 2;
  localparam int STA_WRITE_COLLISION = 3;
  localparam int STA_BCOL = 4;
  localparam int STA_BUSY = 5;

  // Reset values.
  localparam logic [7:0] BAUD_RST = 8'h09;
  localparam logic       EN_RST   = 1'b1;

  // Bit indices within a byte transfer.
  localparam logic [3:0] BIT_LAST_DATA = 4'h7;
  localparam logic [3:0] BIT_ACK       = 4'h8;

  // Sequencer states, one-hot.
  typedef enum logic [10:0] {
    S_IDLE     = 11'h001,
    S_ST_WAIT  = 11'h002,
    S_ST_HOLD  = 11'h004,
    S_RS_LOW   = 11'h008,
    S_RS_REL   = 11'h010,
    S_RS_SCLW  = 11'h020,
    S_RS_HIGH  = 11'h040,
    S_RS_SDALO = 11'h080,
    S_BIT_LOW  = 11'h100,
    S_BIT_SCLW = 11'h200,
    S_BIT_HIGH = 11'h400
  } seq_state_e;

endpackage

//--- i2c_seq_monitor.sv
/*
  Port checker for the bus sequencer: register handshake, line timing.
  Assumes it is bound to the sequencer and that both lines have pull-ups.
*/
`timescale 1ns/100ps
module i2c_seq_monitor (
  // Clock and reset.
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Register port.
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [3:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // Line pads.
  input wire logic        scl_i,
  input wire logic        scl_o,
  input wire logic        scl_oe_o,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_o
);
  import i2c_seq_pkg::*;
  logic       req;
  logic [7:0] baud_q;
  logic [7:0] lcnt_q;
  logic [7:0] hcnt_q;
  assign req = cyc_i && stb_i && !ack_o;
  // Shadow of the reload value, taken at the edge that accepts the write.
  always_ff @(posedge clk_i) begin
    if (rst_i) baud_q <= BAUD_RST;
    else if (req && we_i && adr_i == OFF_BAUD && sel_i[0]) baud_q <= dat_i[7:0];
  end
  // Counters saturate so that a held line does not wrap into a false short phase.
  always_ff @(posedge clk_i) begin
    if (rst_i || !scl_oe_o) lcnt_q <= 8'h00;
    else if (lcnt_q != 8'hFF) lcnt_q <= lcnt_q + 8'h01;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || scl_oe_o || !scl_i) hcnt_q <= 8'h00;
    else if (hcnt_q != 8'hFF) hcnt_q <= hcnt_q + 8'h01;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  ack_answer_a: assert property (req |=> ack_o)
    else $error("request not answered in one cycle");
  reset_idle_a: assert property (disable iff (1'b0) rst_i |=> !scl_oe_o && !sda_oe_o)
    else $error("line pulled after reset");
  open_drain_a: assert property (!scl_o && !sda_o)
    else $error("line driven high");
  unmapped_zero_a: assert property (req && !we_i && adr_i[1:0] != 2'h0 |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  baud_read_a: assert property (req && !we_i && adr_i == OFF_BAUD |=> dat_o[7:0] == baud_q)
    else $error("reload readback wrong");
  low_period_a: assert property ($fell(scl_oe_o) |-> lcnt_q > baud_q)
    else $error("clock low phase short");
  high_period_a: assert property ($rose(scl_oe_o) |-> hcnt_q > baud_q)
    else $error("clock high phase short");
  start_lines_a: assert property ($rose(sda_oe_o) && !scl_oe_o |-> $past(scl_i, 4) && $past(sda_i, 4))
    else $error("start on a busy bus");
  start_hold_a: assert property ($rose(sda_oe_o) && !scl_oe_o |-> (sda_oe_o && !scl_oe_o) [*4])
    else $error("start edge not held");
endmodule // i2c_seq_monitor

bind i2c_master_bus_sequencer i2c_seq_monitor i_mon (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o)
);

//--- i2c_slave_model.sv
/*
  Behavioural bus slave: acknowledges, stretches the clock, records the
  last byte on the wire and returns one byte once addressed for reading.
  Assumes pull-ups on both lines; it only ever pulls a line low.
*/
`timescale 1ns/100ps
module i2c_slave_model (
  // Lines and the clock that times the stretch.
  input  wire logic       clk_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            scl_pull_o,
  output logic            sda_pull_o,
  // Behaviour chosen by the bench.
  input  wire logic       ack_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] tx_i,
  input  wire logic [4:0] stretch_i,
  output logic      [7:0] rx_o
);
  int n = 0;
  int nb = 0;
  int st = 0;
  initial begin
    scl_pull_o = 1'b0;
    sda_pull_o = 1'b0;
    rx_o = 8'h00;
  end
  // A data fall with the clock high opens a new transfer.
  always @(negedge sda_i) begin
    if (scl_i) begin
      n = 0;
      nb = 0;
    end
  end
  // Bits arrive MSB first and are taken as the clock rises.
  always @(posedge scl_i) begin
    if (n >= 1 && n <= 8) rx_o = {rx_o[6:0], sda_i};
  end
  // Slot nine is the acknowledge; read data only after the address byte.
  always @(negedge scl_i) begin
    if (n == 9) begin
      n = 1;
      nb = nb + 1;
    end else begin
      n = n + 1;
    end
    if (n == 9) sda_pull_o = ack_i && !(rd_i && nb > 0);
    else if (rd_i && nb > 0) sda_pull_o = !tx_i[8 - n];
    else sda_pull_o = 1'b0;
    st = stretch_i;
  end
  // Holding the clock after a fall makes the master wait for it.
  always @(posedge clk_i) begin
    if (st > 0) st = st - 1;
    scl_pull_o <= (st > 0);
  end
endmodule // i2c_slave_model

//--- i2c_master_bus_sequencer_tb.sv
/*
  Bench for the sequencer: Start, byte transmit, Repeated Start, receive,
  refused writes, collisions and a reset in mid-transfer.
  Assumes pull-ups on both lines and the slave model on the far side.
*/
`timescale 1ns/100ps
module i2c_master_bus_sequencer_tb;
  import i2c_seq_pkg::*;
  typedef struct packed {logic [7:0] b; logic a; logic [4:0] s;} row_s;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [3:0]  adr_i = 4'h0;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, rd, st;
  logic        ack_o, scl_o, sda_o, scl_oe_o, sda_oe_o, s_scl, s_sda;
  logic        tb_sda = 1'b0;
  logic        ack = 1'b1;
  logic        rdm = 1'b0;
  logic [4:0]  stch = 5'h00;
  logic [7:0]  rxb;
  wire         scl = !(scl_oe_o || s_scl);
  wire         sda = !(sda_oe_o || s_sda || tb_sda);
  int          errors = 0;
  int          num_checks = 0;
  row_s        rows [4] = '{'{8'hA5, 1'b1, 5'h00}, '{8'h3C, 1'b0, 5'h00},
                            '{8'h81, 1'b1, 5'h14}, '{8'h00, 1'b0, 5'h00}};
  logic [31:0] col [2] = '{32'h82, 32'h81};

  i2c_master_bus_sequencer i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o));
  i2c_slave_model i_slv (.clk_i(clk_i), .scl_i(scl), .sda_i(sda), .scl_pull_o(s_scl),
    .sda_pull_o(s_sda), .ack_i(ack), .rd_i(rdm), .tx_i(8'hC3), .stretch_i(stch),
    .rx_o(rxb));

  // 40 MHz system clock.
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  // Classic cycle: the request stands until ack is seen at an edge.
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= d;
    // No cycle count is assumed here; only the watchdog ends a lost answer.
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // Polls status until a flag shows, keeps that word, then clears the flags.
  task automatic wait_st(input logic [31:0] m);
    int t;
    t = 0;
    do begin
      wb(1'b0, OFF_STAT, 32'h0);
      t++;
    end while ((rd & m) !== m && t < 500);
    st = rd;
    chk("status flag", m, st & m);
    wb(1'b1, OFF_STAT, 32'h1E);
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // The full sequence takes well under two thousand cycles.
  initial begin
    repeat (40000) @(posedge clk_i);
    errors++;
    complete_run();
  end

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, OFF_BAUD, 32'h103);
    wb(1'b0, OFF_BAUD, 32'h0);
    chk("baud reload", 32'h03, rd);
    // Start, with a buffer write behind it that must be refused.
    wb(1'b1, OFF_CTRL, 32'h81);
    wb(1'b1, OFF_DATA, 32'h77);
    wait_st(32'h4);
    chk("start flags", 32'h0A, st & 32'h0B);
    chk("start lines", 32'h2, {30'h0, scl, sda});
    wb(1'b0, OFF_CTRL, 32'h0);
    chk("start request", 32'h0, rd & 32'h1);
    foreach (rows[i]) begin
      ack <= rows[i].a;
      stch <= rows[i].s;
      wb(1'b1, OFF_DATA, {24'h0, rows[i].b});
      wb(1'b0, OFF_STAT, 32'h0);
      chk("full and busy", 32'h21, rd & 32'h21);
      wait_st(32'h4);
      chk("full cleared", 32'h0, st & 32'h1);
      chk("wire byte", {24'h0, rows[i].b}, {24'h0, rxb});
      chk("clock held", 32'h0, {31'h0, scl});
      wb(1'b0, OFF_CTRL, 32'h0);
      chk("ack status", {25'h0, !rows[i].a, 6'h0}, rd & 32'h40);
    end
    // Writes and requests during a transfer are refused.
    ack <= 1'b1;
    stch <= 5'h00;
    wb(1'b1, OFF_DATA, 32'h5A);
    wb(1'b1, OFF_DATA, 32'h11);
    wb(1'b1, OFF_CTRL, 32'h8A);
    wait_st(32'h4);
    chk("write collision", 32'h8, st & 32'h8);
    wb(1'b0, OFF_DATA, 32'h0);
    chk("buffer kept", 32'h5A, rd & 32'hFF);
    wb(1'b0, OFF_CTRL, 32'h0);
    chk("late requests", 32'h0, rd & 32'h0A);
    // Repeated Start, read address, then one received byte.
    rdm <= 1'b1;
    wb(1'b1, OFF_CTRL, 32'h82);
    wait_st(32'h4);
    chk("restart detect", 32'h2, st & 32'h2);
    chk("restart lines", 32'h0, {30'h0, scl, sda});
    wb(1'b0, OFF_CTRL, 32'h0);
    chk("restart request", 32'h0, rd & 32'h2);
    wb(1'b1, OFF_DATA, 32'hA1);
    wait_st(32'h4);
    wb(1'b1, OFF_CTRL, 32'h88);
    wait_st(32'h4);
    chk("receive full", 32'h1, st & 32'h1);
    wb(1'b0, OFF_CTRL, 32'h0);
    chk("receive enable", 32'h0, rd & 32'h8);
    wb(1'b0, OFF_DATA, 32'h0);
    chk("received byte", 32'hC3, rd & 32'hFF);
    wb(1'b0, OFF_STAT, 32'h0);
    chk("buffer drained", 32'h0, rd & 32'h1);
    // A foreign master holds data low: Repeated Start, then Start, collide.
    rdm <= 1'b0;
    tb_sda <= 1'b1;
    foreach (col[i]) begin
      wb(1'b1, OFF_CTRL, col[i]);
      wait_st(32'h10);
      wb(1'b0, OFF_CTRL, 32'h0);
      chk("aborted request", 32'h0, rd & 32'h3);
      chk("clock released", 32'h1, {31'h0, scl});
    end
    tb_sda <= 1'b0;
    // Reset in mid-byte ends the transfer and restores the registers.
    wb(1'b1, OFF_DATA, 32'h3C);
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk("lines after reset", 32'h0, {30'h0, scl_oe_o, sda_oe_o});
    wb(1'b0, OFF_CTRL, 32'h0);
    chk("control reset", 32'h80, rd & 32'hBF);
    wb(1'b0, OFF_STAT, 32'h0);
    chk("status reset", 32'h0, rd & 32'h3F);
    wb(1'b0, OFF_BAUD, 32'h0);
    chk("baud reset", {24'h0, BAUD_RST}, rd);
    wb(1'b0, 4'h6, 32'h0);
    chk("unmapped read", 32'h0, rd);
    complete_run();
  end
endmodule // i2c_master_bus_sequencer_tb
